// file: hdl/rcd_bcd_step.sv
// two-digit bcd increment with wrap to a first value after a last value
`timescale 1ns/10ps
module rcd_bcd_step (
   input wire logic [7:0] val,
   input wire logic [7:0] last,
   input wire logic [7:0] first,
   output logic [7:0] nxt,
   output logic wrap
);
   wire logic [7:0] plain_inc;
   assign wrap = (val == last);
   assign plain_inc = (val[3:0] == 4'h9) ? {val[7:4] + 4'h1, 4'h0} : val + 8'h01;
   assign nxt = wrap ? first : plain_inc;
endmodule

// file: hdl/rcd_calendar.sv
// calendar date registers: day of month, month, year, leap phase, hour format
// Operation
// - day register holds bcd 1..31 in bits 5-0, bits 7-6 read zero
// - month field is five-bit bcd 01..12, upper three bits read zero
// - month location: page 0 shows month, page 1 shows hour format in bit 0
// - year location page 0 shows eight-bit bcd year 00..99
// - year location page 1 shows two-bit leap phase, bits 7-2 zero
// - 12-hour mode uses hour bit 5 as pm flag, hours 0..11; else 0..23
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module rcd_calendar (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic page_sel,
   input wire logic day_tick,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data_q,
   output logic [5:0] dom_q,
   output logic [4:0] lunar_q,
   output logic [7:0] annum_q,
   output logic [1:0] leap_q,
   output logic hour_fmt_q,
   output logic [7:0] hour_max_q,
   output logic [5:0] hour_pm_mask_q
);
   ////////////////////////////////////////////////////////////////////////////
   // last day of the month in bcd
   function automatic logic [7:0] month_last_day(input logic [4:0] mon, input logic [1:0] leap);
      logic [7:0] m;
      m = {3'h0, mon};
      if (m == rcd_pkg::LUNAR_FEB) begin
         month_last_day = (leap == rcd_pkg::LEAP_PHASE) ? rcd_pkg::DOM_29 : rcd_pkg::DOM_28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         month_last_day = rcd_pkg::DOM_30;
      end else begin
         month_last_day = rcd_pkg::DOM_31;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic hit_dom;
   wire logic hit_lunar;
   wire logic hit_annum;
   wire logic wr_dom;
   wire logic wr_lunar;
   wire logic wr_fmt;
   wire logic wr_annum;
   wire logic wr_leap;
   wire logic any_cal_wr;
   assign hit_dom = (addr == rcd_pkg::ADDR_DOM);
   assign hit_lunar = (addr == rcd_pkg::ADDR_LUNAR);
   assign hit_annum = (addr == rcd_pkg::ADDR_ANNUM);
   assign wr_dom = wr_en && hit_dom;
   assign wr_lunar = wr_en && hit_lunar && (page_sel == rcd_pkg::PAGE_0);
   assign wr_fmt = wr_en && hit_lunar && (page_sel == rcd_pkg::PAGE_1);
   assign wr_annum = wr_en && hit_annum && (page_sel == rcd_pkg::PAGE_0);
   assign wr_leap = wr_en && hit_annum && (page_sel == rcd_pkg::PAGE_1);
   assign any_cal_wr = wr_dom || wr_lunar || wr_annum || wr_leap;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [7:0] rd_mux;
   wire logic [7:0] lunar_view;
   wire logic [7:0] annum_view;
   assign lunar_view = (page_sel == rcd_pkg::PAGE_0) ? {3'h0, lunar_q} : {7'h00, hour_fmt_q};
   assign annum_view = (page_sel == rcd_pkg::PAGE_0) ? annum_q : {6'h00, leap_q};
   assign rd_mux = hit_dom ? {2'h0, dom_q} :
      hit_lunar ? lunar_view :
      hit_annum ? annum_view : rcd_pkg::BCD_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // date advance chain
   wire logic [7:0] dom_last;
   wire logic [7:0] dom_nxt;
   wire logic dom_wrap;
   wire logic [7:0] lunar_nxt;
   wire logic lunar_wrap;
   wire logic [7:0] annum_nxt;
   wire logic adv;
   wire logic adv_lunar;
   wire logic adv_annum;
   assign dom_last = month_last_day(lunar_q, leap_q);
   // a day, month, year or leap write in the same cycle wins and the day tick is dropped
   assign adv = day_tick && !any_cal_wr;
   assign adv_lunar = adv && dom_wrap;
   assign adv_annum = adv_lunar && lunar_wrap;

   rcd_bcd_step u_dom_step (
      .val({2'h0, dom_q}),
      .last(dom_last),
      .first(rcd_pkg::BCD_ONE),
      .nxt(dom_nxt),
      .wrap(dom_wrap)
   );
   rcd_bcd_step u_lunar_step (
      .val({3'h0, lunar_q}),
      .last(rcd_pkg::LUNAR_DEC),
      .first(rcd_pkg::BCD_ONE),
      .nxt(lunar_nxt),
      .wrap(lunar_wrap)
   );
   // nothing counts above the year, so its wrap stays open
   rcd_bcd_step u_annum_step (
      .val(annum_q),
      .last(rcd_pkg::ANNUM_LAST),
      .first(rcd_pkg::BCD_ZERO),
      .nxt(annum_nxt),
      .wrap()
   );

   ////////////////////////////////////////////////////////////////////////////
   // next values
   wire logic [5:0] dom_d;
   wire logic [4:0] lunar_d;
   wire logic [7:0] annum_d;
   wire logic [1:0] leap_d;
   wire logic hour_fmt_d;
   assign dom_d = wr_dom ? wr_data[5:0] : (adv ? dom_nxt[5:0] : dom_q);
   assign lunar_d = wr_lunar ? wr_data[4:0] : (adv_lunar ? lunar_nxt[4:0] : lunar_q);
   assign annum_d = wr_annum ? wr_data : (adv_annum ? annum_nxt : annum_q);
   assign leap_d = wr_leap ? wr_data[1:0] : (adv_annum ? leap_q + 2'h1 : leap_q);
   assign hour_fmt_d = wr_fmt ? wr_data[rcd_pkg::HOUR_FMT_BIT] : hour_fmt_q;

   ////////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dom_q <= rcd_pkg::DOM_RST;
         lunar_q <= rcd_pkg::LUNAR_RST;
         annum_q <= rcd_pkg::ANNUM_RST;
         leap_q <= rcd_pkg::LEAP_RST;
         hour_fmt_q <= rcd_pkg::HOUR_FMT_RST;
      end else if (ce) begin
         dom_q <= dom_d;
         lunar_q <= lunar_d;
         annum_q <= annum_d;
         leap_q <= leap_d;
         hour_fmt_q <= hour_fmt_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data_q <= rcd_pkg::BCD_ZERO;
      end else if (ce) begin
         rd_data_q <= rd_en ? rd_mux : rcd_pkg::BCD_ZERO;
      end
   end

   // hour chain limits follow the format select
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hour_max_q <= rcd_pkg::HOUR_MAX_12;
         hour_pm_mask_q <= rcd_pkg::HOUR_PM_MASK;
      end else if (ce) begin
         hour_max_q <= hour_fmt_q ? rcd_pkg::HOUR_MAX_24 : rcd_pkg::HOUR_MAX_12;
         hour_pm_mask_q <= hour_fmt_q ? 6'h00 : rcd_pkg::HOUR_PM_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_DOM_READ: assert property (
      ce && rd_en && hit_dom |=> rd_data_q[7:6] == 2'h0 && rd_data_q[5:0] == $past(dom_q))
      else $error("day read does not show day field with zero top bits");
   AST_LUNAR_READ: assert property (
      ce && rd_en && hit_lunar && !page_sel |=> rd_data_q == {3'h0, $past(lunar_q)})
      else $error("month read on page 0 is wrong");
   AST_FMT_READ: assert property (
      ce && rd_en && hit_lunar && page_sel |=> rd_data_q == {7'h00, $past(hour_fmt_q)})
      else $error("hour format read on page 1 is wrong");
   AST_FMT_WRITE: assert property (
      ce && wr_fmt ##1 !ce [*2] |-> hour_fmt_q == $past(wr_data[rcd_pkg::HOUR_FMT_BIT], 2))
      else $error("hour format write not held");
   AST_ANNUM_READ: assert property (
      ce && rd_en && hit_annum && !page_sel |=> rd_data_q == $past(annum_q))
      else $error("year read on page 0 is wrong");
   AST_LEAP_READ: assert property (
      ce && rd_en && hit_annum && page_sel |=> rd_data_q == {6'h00, $past(leap_q)})
      else $error("leap phase read on page 1 is wrong");
   AST_HOUR_LIMIT: assert property (
      ce |=> hour_max_q == ($past(hour_fmt_q) ? rcd_pkg::HOUR_MAX_24 : rcd_pkg::HOUR_MAX_12))
      else $error("hour limit does not follow format select");
   AST_LEAP_ADV: assert property (
      ce && adv && dom_q == 6'h31 && lunar_q == 5'h12 |=> leap_q == $past(leap_q) + 2'h1 && dom_q == 6'h01)
      else $error("leap phase did not advance at year rollover");
   AST_FEB29: assert property (
      ce && adv && lunar_q == 5'h02 && dom_q == 6'h28 && leap_q != 2'h0 |=> dom_q == 6'h01 && lunar_q == 5'h03)
      else $error("february 29 reached outside leap phase zero");
   AST_FEB29_LEAP: assert property (
      ce && adv && lunar_q == 5'h02 && dom_q == 6'h28 && leap_q == 2'h0 |=> dom_q == 6'h29 && lunar_q == 5'h02)
      else $error("february 29 missing in leap phase zero");
   AST_ANNUM_WRAP: assert property (
      ce && adv_annum && annum_q == rcd_pkg::ANNUM_LAST |=> annum_q == rcd_pkg::BCD_ZERO)
      else $error("year did not wrap from 99 to 00");
   AST_HOUR_MASK: assert property (
      ce |=> hour_pm_mask_q == ($past(hour_fmt_q) ? 6'h00 : rcd_pkg::HOUR_PM_MASK))
      else $error("pm flag mask does not follow format select");
   AST_DOM_WRITE: assert property (
      ce && wr_dom |=> dom_q == $past(wr_data[5:0]))
      else $error("day write did not land");
   AST_LUNAR_WRITE: assert property (
      ce && wr_lunar |=> lunar_q == $past(wr_data[4:0]))
      else $error("month write did not land");
   AST_ANNUM_WRITE: assert property (
      ce && wr_annum |=> annum_q == $past(wr_data))
      else $error("year write did not land");
   AST_LEAP_WRITE: assert property (
      ce && wr_leap |=> leap_q == $past(wr_data[1:0]))
      else $error("leap phase write did not land");
endmodule

// file: hdl/rcd_pkg.sv
// shared constants of the calendar date block
package rcd_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_DOM = 8'h00;
   localparam logic [7:0] ADDR_LUNAR = 8'h04;
   localparam logic [7:0] ADDR_ANNUM = 8'h08;
   // field widths
   localparam int DOM_W = 6;
   localparam int LUNAR_W = 5;
   localparam int ANNUM_W = 8;
   localparam int LEAP_W = 2;
   // bit position of the hour format select on page 1
   localparam int HOUR_FMT_BIT = 0;
   // reset values
   localparam logic [5:0] DOM_RST = 6'h01;
   localparam logic [4:0] LUNAR_RST = 5'h01;
   localparam logic [7:0] ANNUM_RST = 8'h00;
   localparam logic [1:0] LEAP_RST = 2'h0;
   localparam logic HOUR_FMT_RST = 1'b0;
   // calendar limits in bcd
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] LUNAR_FEB = 8'h02;
   localparam logic [7:0] LUNAR_DEC = 8'h12;
   localparam logic [7:0] ANNUM_LAST = 8'h99;
   localparam logic [7:0] DOM_28 = 8'h28;
   localparam logic [7:0] DOM_29 = 8'h29;
   localparam logic [7:0] DOM_30 = 8'h30;
   localparam logic [7:0] DOM_31 = 8'h31;
   localparam logic [1:0] LEAP_PHASE = 2'h0;
   // hour field limits for the hour chain
   localparam logic [7:0] HOUR_MAX_12 = 8'h11;
   localparam logic [7:0] HOUR_MAX_24 = 8'h23;
   localparam logic [5:0] HOUR_PM_MASK = 6'h20;
   // page encodings
   localparam logic PAGE_0 = 1'b0;
   localparam logic PAGE_1 = 1'b1;
endpackage

// file: tb/rcd_calendar_bench.sv
// self-checking bench of the calendar date registers
`timescale 1ns/10ps
module rcd_calendar_bench;
   logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b0, page_sel = 1'b0, go = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data_q, annum_q, hour_max_q, y, m, d;
   logic [5:0] dom_q, hour_pm_mask_q;
   logic [4:0] lunar_q;
   logic [1:0] leap_q;
   logic hour_fmt_q, day_tick;
   int err_total = 0, check_count = 0;
   always #2 core_clk = ~core_clk;
   rcd_tick_src tick_u (.core_clk(core_clk), .rst_n(rst_n), .go(go), .day_tick(day_tick));
   rcd_calendar dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .page_sel(page_sel), .day_tick(day_tick),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .dom_q(dom_q),
      .lunar_q(lunar_q), .annum_q(annum_q), .leap_q(leap_q), .hour_fmt_q(hour_fmt_q), .hour_max_q(hour_max_q),
      .hour_pm_mask_q(hour_pm_mask_q));
   ////////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic pg, input logic [7:0] a, input logic [7:0] dt);
      @(posedge core_clk);
      page_sel <= pg;
      addr <= a;
      wr_data <= dt;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic pg, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      page_sel <= pg;
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 chk(rd_data_q, exp);
   endtask
   // request one day advance and wait until it has landed
   task tick;
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task date_chk(input logic [7:0] ed, input logic [7:0] em, input logic [7:0] ey, input logic [1:0] el);
      chk({2'b00, dom_q}, ed);
      chk({3'b000, lunar_q}, em);
      chk(annum_q, ey);
      chk({6'h00, leap_q}, {6'h00, el});
   endtask
   function automatic logic [7:0] bcd(input int n);
      return 8'((n / 10) * 16 + n % 10);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(97007));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      rd(1'b0, rcd_pkg::ADDR_DOM, 8'h01);
      rd(1'b0, rcd_pkg::ADDR_LUNAR, 8'h01);
      rd(1'b0, rcd_pkg::ADDR_ANNUM, 8'h00);
      rd(1'b1, rcd_pkg::ADDR_LUNAR, 8'h00);
      rd(1'b1, rcd_pkg::ADDR_ANNUM, 8'h00);
      chk(hour_max_q, 8'h11);
      chk({2'b00, hour_pm_mask_q}, 8'h20);
      rd(1'b0, 8'h0C, 8'h00);
      $display("test reset done");
      wr(1'b0, rcd_pkg::ADDR_DOM, 8'hD5);
      rd(1'b0, rcd_pkg::ADDR_DOM, 8'h15);
      wr(1'b0, rcd_pkg::ADDR_LUNAR, 8'hF2);
      wr(1'b1, rcd_pkg::ADDR_LUNAR, 8'hFF);
      rd(1'b1, rcd_pkg::ADDR_LUNAR, 8'h01);
      chk({7'h00, hour_fmt_q}, 8'h01);
      rd(1'b0, rcd_pkg::ADDR_LUNAR, 8'h12);
      chk(hour_max_q, 8'h23);
      chk({2'b00, hour_pm_mask_q}, 8'h00);
      wr(1'b1, rcd_pkg::ADDR_ANNUM, 8'hFE);
      rd(1'b1, rcd_pkg::ADDR_ANNUM, 8'h02);
      rd(1'b0, rcd_pkg::ADDR_ANNUM, 8'h00);
      $display("test pages done");
      for (int i = 0; i < 16; i++) begin
         y = bcd($urandom_range(99));
         m = bcd($urandom_range(12, 1));
         d = bcd($urandom_range(28, 1));
         wr(1'b0, rcd_pkg::ADDR_ANNUM, y);
         wr(1'b0, rcd_pkg::ADDR_LUNAR, m);
         wr(1'b0, rcd_pkg::ADDR_DOM, d);
         rd(1'b0, rcd_pkg::ADDR_ANNUM, y);
         rd(1'b0, rcd_pkg::ADDR_LUNAR, m);
         rd(1'b0, rcd_pkg::ADDR_DOM, d);
      end
      $display("test random done");
      wr(1'b0, rcd_pkg::ADDR_DOM, 8'h31);
      wr(1'b0, rcd_pkg::ADDR_LUNAR, 8'h12);
      wr(1'b0, rcd_pkg::ADDR_ANNUM, 8'h99);
      wr(1'b1, rcd_pkg::ADDR_ANNUM, 8'h03);
      tick;
      date_chk(8'h01, 8'h01, 8'h00, 2'h0);
      wr(1'b0, rcd_pkg::ADDR_LUNAR, 8'h02);
      wr(1'b0, rcd_pkg::ADDR_DOM, 8'h28);
      tick;
      date_chk(8'h29, 8'h02, 8'h00, 2'h0);
      tick;
      date_chk(8'h01, 8'h03, 8'h00, 2'h0);
      wr(1'b1, rcd_pkg::ADDR_ANNUM, 8'h01);
      wr(1'b0, rcd_pkg::ADDR_LUNAR, 8'h02);
      wr(1'b0, rcd_pkg::ADDR_DOM, 8'h28);
      tick;
      date_chk(8'h01, 8'h03, 8'h00, 2'h1);
      @(posedge core_clk);
      ce <= 1'b0;
      tick;
      date_chk(8'h01, 8'h03, 8'h00, 2'h1);
      @(posedge core_clk);
      ce <= 1'b1;
      $display("test rollover done");
      // the format is written just before the enable drops for two cycles
      wr(1'b1, rcd_pkg::ADDR_LUNAR, 8'h00);
      ce <= 1'b0;
      repeat (2) @(posedge core_clk);
      ce <= 1'b1;
      chk({7'h00, hour_fmt_q}, 8'h00);
      rd(1'b1, rcd_pkg::ADDR_LUNAR, 8'h00);
      chk(hour_max_q, 8'h11);
      chk({2'b00, hour_pm_mask_q}, 8'h20);
      $display("test format done");
      @(posedge core_clk);
      rst_n <= 1'b0;
      @(posedge core_clk);
      rst_n <= 1'b1;
      #1 date_chk(8'h01, 8'h01, 8'h00, 2'h0);
      rd(1'b1, rcd_pkg::ADDR_ANNUM, 8'h00);
      $display("test mid reset done");
      complete_run;
   end
   initial begin
      #100000;
      err_total++;
      complete_run;
   end
endmodule

// file: tb/rcd_tick_src.sv
// day tick source standing in for the hour chain
`timescale 1ns/10ps
module rcd_tick_src (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic go,
   output logic day_tick
);
   // one-cycle pulse per request, silent while in reset
   always_ff @(posedge core_clk) begin
      day_tick <= rst_n & go;
   end
endmodule
